// [src/sfp_pkg.sv]
// Constants and types for the serial flash status and protection front end
package sfp_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam logic [7:0]  OP_UNLOCK       = 8'h06;
  localparam logic [7:0]  OP_LOCK         = 8'h04;
  localparam logic [7:0]  OP_STAT_READ    = 8'h05;
  localparam logic [7:0]  OP_STAT_WRITE   = 8'h01;
  localparam logic [7:0]  OP_PAGE_PROG    = 8'h02;
  localparam logic [7:0]  OP_SECT_ERASE_A = 8'hd7;
  localparam logic [7:0]  OP_SECT_ERASE_B = 8'h20;
  localparam logic [7:0]  OP_BLOCK_ERASE  = 8'hd8;
  localparam logic [7:0]  OP_CHIP_ERASE_A = 8'hc7;
  localparam logic [7:0]  OP_CHIP_ERASE_B = 8'h60;
  localparam int unsigned BUSY_POS        = 0;
  localparam int unsigned LATCH_POS       = 1;
  localparam int unsigned GUARD_LSB       = 2;
  localparam int unsigned LOCK_POS        = 7;
  localparam logic [7:0]  STATUS_RESET    = 8'h00;
  localparam logic [23:0] ARRAY_TOP       = 24'h07ffff;
  localparam logic [23:0] BLOCK_SIZE      = 24'h010000;
  localparam logic [23:0] SECTOR_SIZE     = 24'h001000;
  localparam logic [23:0] GUARD_BASE_1    = 24'h070000;
  localparam logic [23:0] GUARD_BASE_2    = 24'h060000;
  localparam logic [23:0] GUARD_BASE_3    = 24'h040000;
  localparam logic [23:0] GUARD_BASE_ALL  = 24'h000000;
  localparam logic [15:0] BUSY_CYCLES     = 16'h0040;
  typedef struct packed {
    logic       status_lock_bit;
    logic [1:0] reserved;
    logic [2:0] area_guard;
    logic       write_latch_flag;
    logic       write_busy_flag;
  } sfp_status_type;
  typedef enum logic [2:0] {OPC_NONE, OPC_STATW, OPC_PROG, OPC_SECT, OPC_BLK, OPC_CHIP}
    sfp_op_type;
endpackage

// [src/sfp_flash_front.sv]
// Serial front end with status register and area protection
`timescale 1ns/100ps
module sfp_flash_front (
  input  wire logic                   REF_CLK,
  input  wire logic                   RST_B,
  input  wire logic                   SEL_B,
  input  wire logic                   SCLK,
  input  wire logic                   SERIAL_IN_OUT_I,
  input  wire logic                   PROTECT_B,
  output logic                        SO,
  output logic                        SO_OE,
  output logic                        SERIAL_IN_OUT_O,
  output logic                        SERIAL_IN_OUT_OE,
  output sfp_pkg::sfp_status_type     STATUS,
  output logic                        OP_START,
  output sfp_pkg::sfp_op_type         OP_KIND,
  output logic [23:0]                 OP_ADDR
);
  import sfp_pkg::*;

  logic [1:0]  sel_sync_ff, clk_sync_ff, din_sync_ff, wp_sync_ff;
  logic        clk_prev_ff;
  logic [31:0] shift_ff, nxt_shift;
  logic [31:0] head_ff, nxt_head;
  logic [5:0]  bit_cnt_ff, nxt_bit_cnt;
  logic [7:0]  out_ff, nxt_out;
  logic        so_ff, nxt_so, so_oe_ff, nxt_so_oe;
  logic        reading_ff, nxt_reading;
  logic        latch_ff, nxt_latch;
  logic [2:0]  guard_ff, nxt_guard;
  logic        lock_ff, nxt_lock;
  logic [15:0] busy_cnt_ff, nxt_busy_cnt;
  logic        start_ff, nxt_start;
  sfp_op_type  kind_ff, nxt_kind;
  logic [23:0] addr_ff, nxt_addr;
  logic [7:0]  opcode;
  logic        sel_b, sclk, rise, fall, desel_edge, busy;
  logic [23:0] guard_base, cmd_addr;
  sfp_status_type status_now;

  // Two-stage synchronisers for SEL_B, SCLK, SERIAL_IN_OUT_I and PROTECT_B
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sel_sync_ff <= 2'h3;
      clk_sync_ff <= 2'h0;
      din_sync_ff <= 2'h0;
      wp_sync_ff  <= 2'h3;
      clk_prev_ff <= 1'b0;
    end else begin
      sel_sync_ff <= {sel_sync_ff[0], SEL_B};
      clk_sync_ff <= {clk_sync_ff[0], SCLK};
      din_sync_ff <= {din_sync_ff[0], SERIAL_IN_OUT_I};
      wp_sync_ff  <= {wp_sync_ff[0], PROTECT_B};
      clk_prev_ff <= clk_sync_ff[1];
    end
  end

  assign sel_b      = sel_sync_ff[1];
  assign sclk       = clk_sync_ff[1];
  // Edges seen only while selected, so mode 3 idle-high does not count
  assign rise       = !sel_b && sclk && !clk_prev_ff;
  assign fall       = !sel_b && !sclk && clk_prev_ff;
  assign busy       = busy_cnt_ff != 16'h0000;
  assign opcode     = (bit_cnt_ff >= 6'd32) ? head_ff[31:24] :
                      (bit_cnt_ff >= 6'd8)  ? shift_ff[7:0] : 8'h00;
  assign cmd_addr   = head_ff[23:0] & ARRAY_TOP;

  // Protected region start per guard code
  always_comb begin
    unique case (guard_ff)
      3'h0:    guard_base = ARRAY_TOP;
      3'h1:    guard_base = GUARD_BASE_1;
      3'h2:    guard_base = GUARD_BASE_2;
      3'h3:    guard_base = GUARD_BASE_3;
      default: guard_base = GUARD_BASE_ALL;
    endcase
  end

  always_comb begin
    status_now                  = '0;
    status_now.write_busy_flag  = busy;
    status_now.write_latch_flag = latch_ff;
    status_now.area_guard       = guard_ff;
    status_now.status_lock_bit  = lock_ff;
  end

  // Deselect edge closes a frame
  logic sel_prev_ff;
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) sel_prev_ff <= 1'b1;
    else        sel_prev_ff <= sel_b;
  end
  assign desel_edge = sel_b && !sel_prev_ff;

  always_comb begin
    logic guarded_ok;
    guarded_ok   = 1'b0;
    nxt_shift    = shift_ff;
    nxt_head     = head_ff;
    nxt_bit_cnt  = bit_cnt_ff;
    nxt_out      = out_ff;
    nxt_so       = so_ff;
    nxt_so_oe    = so_oe_ff;
    nxt_reading  = reading_ff;
    nxt_latch    = latch_ff;
    nxt_guard    = guard_ff;
    nxt_lock     = lock_ff;
    nxt_busy_cnt = busy ? busy_cnt_ff - 16'h0001 : busy_cnt_ff;
    nxt_start    = 1'b0;
    nxt_kind     = kind_ff;
    nxt_addr     = addr_ff;
    if (busy && busy_cnt_ff == 16'h0001)
      nxt_latch = 1'b0;
    if (sel_b) begin
      nxt_bit_cnt = 6'd0;
      nxt_reading = 1'b0;
      nxt_so_oe   = 1'b0;
    end else if (rise) begin
      nxt_shift   = {shift_ff[30:0], din_sync_ff[1]};
      // Opcode and address kept once the fourth byte lands
      if (bit_cnt_ff == 6'd31)
        nxt_head = {shift_ff[30:0], din_sync_ff[1]};
      // Long frames cycle 56..63 so byte alignment stays visible
      nxt_bit_cnt = (bit_cnt_ff == 6'd63) ? 6'd56 : bit_cnt_ff + 6'd1;
      if (bit_cnt_ff == 6'd7 && {shift_ff[6:0], din_sync_ff[1]} == OP_STAT_READ) begin
        nxt_reading = 1'b1;
        nxt_out     = status_now;
      end
    end else if (fall && reading_ff) begin
      nxt_so_oe = 1'b1;
      nxt_so    = out_ff[7];
      nxt_out   = (bit_cnt_ff[2:0] == 3'd0) ? {status_now[6:0], 1'b0} :
                                             {out_ff[6:0], 1'b0};
      if (bit_cnt_ff[2:0] == 3'd0)
        nxt_so = status_now[7];
    end
    if (desel_edge && !busy && bit_cnt_ff[2:0] == 3'd0) begin
      if (bit_cnt_ff == 6'd8 && opcode == OP_UNLOCK)
        nxt_latch = 1'b1;
      else if (bit_cnt_ff == 6'd8 && opcode == OP_LOCK)
        nxt_latch = 1'b0;
      else if (latch_ff) begin
        if (bit_cnt_ff == 6'd16 && shift_ff[15:8] == OP_STAT_WRITE) begin
          if (!(lock_ff && !wp_sync_ff[1])) begin
            nxt_guard    = shift_ff[GUARD_LSB +: 3];
            nxt_lock     = shift_ff[LOCK_POS];
            nxt_busy_cnt = BUSY_CYCLES;
            nxt_start    = 1'b1;
            nxt_kind     = OPC_STATW;
          end
        end else if (bit_cnt_ff == 6'd8 &&
                     (opcode == OP_CHIP_ERASE_A || opcode == OP_CHIP_ERASE_B)) begin
          if (guard_ff == 3'h0) begin
            nxt_busy_cnt = BUSY_CYCLES;
            nxt_start    = 1'b1;
            nxt_kind     = OPC_CHIP;
            nxt_addr     = 24'h000000;
          end
        end else if (bit_cnt_ff >= 6'd32) begin
          guarded_ok = (guard_ff == 3'h0) || (cmd_addr < guard_base);
          if (opcode == OP_SECT_ERASE_A || opcode == OP_SECT_ERASE_B) begin
            nxt_kind = OPC_SECT;
            nxt_addr = cmd_addr & ~(SECTOR_SIZE - 24'h000001);
          end else if (opcode == OP_BLOCK_ERASE) begin
            nxt_kind = OPC_BLK;
            nxt_addr = cmd_addr & ~(BLOCK_SIZE - 24'h000001);
            guarded_ok = (guard_ff == 3'h0) || (nxt_addr < guard_base);
          end else if (opcode == OP_PAGE_PROG) begin
            nxt_kind = OPC_PROG;
            nxt_addr = cmd_addr;
          end else begin
            guarded_ok = 1'b0;
          end
          if (guarded_ok && (bit_cnt_ff == 6'd32 || opcode == OP_PAGE_PROG)) begin
            nxt_busy_cnt = BUSY_CYCLES;
            nxt_start    = 1'b1;
          end else begin
            nxt_kind = kind_ff;
            nxt_addr = addr_ff;
          end
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      shift_ff    <= 32'h00000000;
      head_ff     <= 32'h00000000;
      bit_cnt_ff  <= 6'd0;
      out_ff      <= STATUS_RESET;
      so_ff       <= 1'b0;
      so_oe_ff    <= 1'b0;
      reading_ff  <= 1'b0;
      latch_ff    <= 1'b0;
      guard_ff    <= 3'h0;
      lock_ff     <= 1'b0;
      busy_cnt_ff <= 16'h0000;
      start_ff    <= 1'b0;
      kind_ff     <= OPC_NONE;
      addr_ff     <= 24'h000000;
    end else begin
      shift_ff    <= nxt_shift;
      head_ff     <= nxt_head;
      bit_cnt_ff  <= nxt_bit_cnt;
      out_ff      <= nxt_out;
      so_ff       <= nxt_so;
      so_oe_ff    <= nxt_so_oe;
      reading_ff  <= nxt_reading;
      latch_ff    <= nxt_latch;
      guard_ff    <= nxt_guard;
      lock_ff     <= nxt_lock;
      busy_cnt_ff <= nxt_busy_cnt;
      start_ff    <= nxt_start;
      kind_ff     <= nxt_kind;
      addr_ff     <= nxt_addr;
    end
  end

  // Status mirror registered so the port comes from a flip-flop
  sfp_status_type status_ff;
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) status_ff <= STATUS_RESET;
    else        status_ff <= status_now;
  end

  assign SO               = so_ff;
  assign SO_OE            = so_oe_ff;
  assign SERIAL_IN_OUT_O  = 1'b0;
  assign SERIAL_IN_OUT_OE = 1'b0;
  assign STATUS           = status_ff;
  assign OP_START         = start_ff;
  assign OP_KIND          = kind_ff;
  assign OP_ADDR          = addr_ff;

  a_desel_float: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    sel_b |=> !SO_OE) else $error("Output driven while deselected");
  a_reserved_zero: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    STATUS.reserved == 2'h0) else $error("Reserved bits not zero");
  // Status port lags one cycle behind the start pulse
  a_busy_start: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    OP_START |=> STATUS.write_busy_flag [*2]) else $error("Busy not set");
  a_latch_needed: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    nxt_start |-> latch_ff) else $error("Operation without latch");
  a_chip_guard: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (nxt_start && nxt_kind == OPC_CHIP) |-> guard_ff == 3'h0)
    else $error("Chip erase while guarded");
  a_lock_hold: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (lock_ff && !wp_sync_ff[1]) |=> $stable(guard_ff) && lock_ff)
    else $error("Locked status changed");
  a_latch_clear: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (busy_cnt_ff == 16'h0001) |=> !latch_ff) else $error("Latch not cleared");
  a_whole_bytes: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (desel_edge && bit_cnt_ff[2:0] != 3'd0) |=> !OP_START)
    else $error("Partial frame accepted");
  a_guard_region: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (nxt_start && (nxt_kind == OPC_PROG || nxt_kind == OPC_SECT) && guard_ff != 3'h0)
    |-> cmd_addr < guard_base) else $error("Guarded address accepted");
endmodule // sfp_flash_front

// [verification/sfp_master_model.sv]
// Serial bus master model that drives frames into the front end
`timescale 1ns/100ps
module sfp_master_model (
  input  wire logic ref_clk,
  input  wire logic so_pin,
  output logic      sel_b,
  output logic      sclk,
  output logic      serial_in_out
);
  logic mode3 = 1'b0;
  initial begin
    sel_b = 1'b1;
    sclk  = 1'b0;
    serial_in_out   = 1'b0;
  end
  // Idle clock level per mode
  task automatic set_mode(input logic m);
    @(negedge ref_clk);
    mode3 = m;
    sclk  = m;
  endtask
  // Data set while clock low, taken on rise, MSB first
  task automatic frame(input int n, input logic [31:0] d, output logic [7:0] rx);
    rx = 8'h00;
    @(negedge ref_clk);
    sel_b = 1'b0;
    repeat (2) @(negedge ref_clk);
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      serial_in_out  = d[i];
      repeat (4) @(negedge ref_clk);
      if (i < 8)
        rx = {rx[6:0], so_pin};
      sclk = 1'b1;
      repeat (4) @(negedge ref_clk);
    end
    sclk = mode3;
    repeat (2) @(negedge ref_clk);
    sel_b = 1'b1;
    // Released line shows inverse of last bit
    serial_in_out = ~serial_in_out;
    repeat (6) @(negedge ref_clk);
  endtask
endmodule // sfp_master_model

// [verification/tb_top.sv]
// Self-checking bench for the serial flash status and protection front end
`timescale 1ns/100ps
module tb_top;
  import sfp_pkg::*;
  logic           ref_clk = 1'b0;
  logic           rst_b = 1'b0;
  logic           protect_b = 1'b1;
  logic           sel_b, sclk, serial_in_out, so, so_oe, op_start;
  sfp_status_type status;
  sfp_op_type     op_kind;
  logic [23:0]    op_addr, base;
  logic [7:0]     rx;
  int             bad_count = 0;
  int             samples_checked = 0;
  int             starts = 0;
  sfp_flash_front DUT (.REF_CLK(ref_clk), .RST_B(rst_b), .SEL_B(sel_b), .SCLK(sclk),
    .SERIAL_IN_OUT_I(serial_in_out), .PROTECT_B(protect_b), .SO(so), .SO_OE(so_oe),
    .SERIAL_IN_OUT_O(), .SERIAL_IN_OUT_OE(), .STATUS(status), .OP_START(op_start),
    .OP_KIND(op_kind), .OP_ADDR(op_addr));
  sfp_master_model m (.ref_clk(ref_clk), .so_pin(so), .sel_b(sel_b), .sclk(sclk), .serial_in_out(serial_in_out));
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) begin
    if (op_start === 1'b1)
      starts++;
  end
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic rd(output logic [7:0] v);
    m.frame(16, {16'h0000, OP_STAT_READ, 8'h00}, v);
  endtask
  // Prefix frame, then one command; counts accepted starts
  task automatic op(input logic [7:0] pre, input int n, input logic [31:0] d, input int acc);
    int s0;
    m.frame(8, {24'h000000, pre}, rx);
    s0 = starts;
    m.frame(n, d, rx);
    repeat (80) @(negedge ref_clk);
    chk("op_start", 24'(acc), 24'(starts - s0));
  endtask
  initial begin
    #4_000_000;
    bad_count++;
    summarize();
  end
  initial begin
    repeat (4) @(negedge ref_clk);
    chk("reset_status", 24'(STATUS_RESET), 24'(status));
    rst_b = 1'b1;
    repeat (4) @(negedge ref_clk);
    rd(rx);
    chk("status_rd", 24'h00, 24'(rx));
    chk("so_oe", 24'h0, 24'(so_oe));
    m.frame(8, {24'h000000, OP_STAT_READ}, rx);
    op(OP_STAT_READ, 16, {16'h0000, OP_STAT_WRITE, 8'h9c}, 0);
    m.set_mode(1'b1);
    m.frame(8, {24'h000000, OP_UNLOCK}, rx);
    rd(rx);
    chk("latch_set", 24'h02, 24'(rx));
    m.frame(16, {16'h0000, OP_STAT_WRITE, 8'hff}, rx);
    repeat (8) @(negedge ref_clk);
    chk("busy_latch", 24'h3, 24'(status[1:0]));
    repeat (80) @(negedge ref_clk);
    rd(rx);
    chk("status_wr", 24'h9c, 24'(rx));
    chk("status_port", 24'h9c, 24'(status));
    protect_b = 1'b0;
    op(OP_UNLOCK, 16, {16'h0000, OP_STAT_WRITE, 8'h00}, 0);
    rd(rx);
    chk("locked", 24'h9c, 24'(rx & 8'h9c));
    protect_b = 1'b1;
    m.set_mode(1'b0);
    op(OP_UNLOCK, 16, {16'h0000, OP_STAT_WRITE, 8'h04}, 1);
    rd(rx);
    chk("guard1", 24'h04, 24'(rx));
    op(OP_UNLOCK, 32, {OP_SECT_ERASE_A, 24'h065123}, 1);
    chk("kind_sect", 24'(OPC_SECT), 24'(op_kind));
    chk("addr_sect", 24'h065000, op_addr);
    op(OP_UNLOCK, 32, {OP_BLOCK_ERASE, 24'h03abcd}, 1);
    chk("kind_blk", 24'(OPC_BLK), 24'(op_kind));
    chk("addr_blk", 24'h030000, op_addr);
    op(OP_UNLOCK, 32, {OP_PAGE_PROG, 24'h012345}, 1);
    chk("kind_prog", 24'(OPC_PROG), 24'(op_kind));
    chk("addr_prog", 24'h012345, op_addr);
    op(OP_UNLOCK, 31, {1'b0, OP_BLOCK_ERASE, 23'h008000}, 0);
    m.frame(8, {24'h000000, OP_UNLOCK}, rx);
    op(OP_LOCK, 32, {OP_BLOCK_ERASE, 24'h010000}, 0);
    for (int g = 1; g < 8; g++) begin
      op(OP_UNLOCK, 16, {16'h0000, OP_STAT_WRITE, 3'b000, 3'(g), 2'b00}, 1);
      base = (g == 1) ? GUARD_BASE_1 : (g == 2) ? GUARD_BASE_2 :
             (g == 3) ? GUARD_BASE_3 : GUARD_BASE_ALL;
      op(OP_UNLOCK, 32, {OP_SECT_ERASE_B, base}, 0);
      if (base != 24'h000000)
        op(OP_UNLOCK, 32, {OP_SECT_ERASE_B, base - SECTOR_SIZE}, 1);
      op(OP_UNLOCK, 8, {24'h000000, OP_CHIP_ERASE_B}, 0);
    end
    op(OP_UNLOCK, 16, {16'h0000, OP_STAT_WRITE, 8'h00}, 1);
    op(OP_UNLOCK, 8, {24'h000000, OP_CHIP_ERASE_A}, 1);
    chk("kind_chip", 24'(OPC_CHIP), 24'(op_kind));
    chk("addr_chip", 24'h000000, op_addr);
    op(OP_UNLOCK, 8, {24'h000000, OP_CHIP_ERASE_B}, 1);
    rd(rx);
    chk("final", 24'h00, 24'(rx));
    summarize();
  end
endmodule // tb_top
